// ==== peripheral_irq_enable_bank_tb_top.sv ====
// Bench for the enable bank: bus tasks, reference model, both variants
`define CHK(g, e) begin nChecks++; if ((g) !== (e)) begin nErrors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module peripheral_irq_enable_bank_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pieb_pkg::*;

  logic             ref_clk = 1'b0;
  logic             rst = 1'b1;
  logic [7:0]       regAddr = 8'h00;
  logic [7:0]       regWrData = 8'h00;
  logic [7:0]       wrDataB;
  logic             regWrEn = 1'b0;
  logic             regRdEn = 1'b0;
  logic [7:0]       fireReq = 8'h00;
  logic [7:0]       srcEvent;
  logic [7:0]       rdA, rdB, expRdA, expRdB;
  logic [7:0]       enA, enB, flA, flB, ctl;
  logic             irqA, irqB, expIrqA, expIrqB;
  int               nErrors = 0;
  int               nChecks = 0;
  int               irqTaken;
  int               pick;
  logic [7:0]       pickData;
  int               srcs[7] = '{0, 1, 2, 3, 4, 5, 7};
  logic [7:0]       addrs[5] = '{PIE_OFFSET, CTRL_OFFSET, FLAG_OFFSET,
                                 FLAG_CLR_OFFSET, 8'h55};

  // Clock at 100 MHz
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  // Lite variant never gets enable bits 7 (parallel) and 6 (reserved) set
  assign wrDataB = (regAddr == PIE_OFFSET) ? (regWrData & 8'h3f)
                                           : regWrData;

  pieb_irq_enable_bank #(.HAS_USART(1'b1), .HAS_PARALLEL(1'b1)) uut (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(rdA),
    .srcEvent(srcEvent), .irqOut(irqA));
  pieb_irq_enable_bank #(.HAS_USART(1'b0), .HAS_PARALLEL(1'b0)) uut2 (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(wrDataB),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(rdB),
    .srcEvent(srcEvent), .irqOut(irqB));
  pieb_periph_model periph (
    .ref_clk(ref_clk), .rst(rst), .fireReq(fireReq), .srcEvent(srcEvent),
    .irqOut(irqA), .irqTaken(irqTaken));

  // Register read value of the reference model
  function automatic logic [7:0] rdv(logic [7:0] a, logic [7:0] e,
                                     logic [7:0] f);
    if (a == PIE_OFFSET) return e;
    if (a == CTRL_OFFSET) return ctl & CTRL_MASK;
    if (a == FLAG_OFFSET) return f;
    return 8'h00;
  endfunction

  // Reference model, one step per clock edge
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      {enA, enB, flA, flB, ctl} <= '0;
      {expRdA, expRdB, expIrqA, expIrqB} <= '0;
    end
    else
    begin
      expIrqA <= ((flA & enA & ~RESERVED_MASK) != 0) &&
                 ctl[GLOBAL_EN_BIT] && ctl[PERIPH_GATE_BIT];
      expIrqB <= ((flB & enB & BASE_SRC_MASK) != 0) &&
                 ctl[GLOBAL_EN_BIT] && ctl[PERIPH_GATE_BIT];
      expRdA <= regRdEn ? rdv(regAddr, enA, flA) : 8'h00;
      expRdB <= regRdEn ? rdv(regAddr, enB, flB) : 8'h00;
      if (regWrEn && regAddr == PIE_OFFSET)
      begin
        enA <= regWrData;
        enB <= wrDataB & ~USART_MASK;
      end
      if (regWrEn && regAddr == CTRL_OFFSET)
        ctl <= regWrData & CTRL_MASK;
      flA <= (flA & ~((regWrEn && regAddr == FLAG_CLR_OFFSET) ? regWrData
             : 8'h00)) | (srcEvent & ~RESERVED_MASK);
      flB <= (flB & ~((regWrEn && regAddr == FLAG_CLR_OFFSET) ? regWrData
             : 8'h00)) | (srcEvent & BASE_SRC_MASK);
    end
  end

  // Every read result and request level against the model
  always @(negedge ref_clk)
  begin
    `CHK(rdA, expRdA)
    `CHK(rdB, expRdB)
    `CHK(irqA, expIrqA)
    `CHK(irqB, expIrqB)
  end

  // Bus and event tasks; each task drops the strobes it does not drive, fireReq drops only in idle
  task automatic wr(logic [7:0] a, logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    regRdEn <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(logic [7:0] a);
    regAddr <= a;
    regRdEn <= 1'b1;
    regWrEn <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic fire(logic [7:0] m);
    fireReq <= m;
    regWrEn <= 1'b0;
    regRdEn <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic idle(int n);
    {regWrEn, regRdEn, fireReq} <= '0;
    repeat (n) @(posedge ref_clk);
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d errors %0d irqs %0d", nChecks, nErrors, irqTaken);
    if (nErrors == 0 && nChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog against a hang
  initial
  begin
    #100000;
    nErrors++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end

  // Main sequence
  initial
  begin
    void'($urandom(91541));
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (addrs[k]) rd(addrs[k]);
    wr(PIE_OFFSET, 8'hbf);
    rd(PIE_OFFSET);
    idle(2);
    // Each source alone: gate, global enable, then enable off
    foreach (srcs[k])
    begin
      wr(FLAG_CLR_OFFSET, 8'hff);
      wr(PIE_OFFSET, 8'h01 << srcs[k]);
      wr(CTRL_OFFSET, 8'hc0);
      fire(8'h01 << srcs[k]);
      idle(3);
      rd(FLAG_OFFSET);
      wr(CTRL_OFFSET, 8'h80);
      idle(2);
      wr(CTRL_OFFSET, 8'h40);
      idle(2);
      wr(CTRL_OFFSET, 8'hc0);
      wr(PIE_OFFSET, 8'h00);
      wr(FLAG_CLR_OFFSET, 8'hff);
      fire(8'h01 << srcs[k]);
      idle(2);
      rd(FLAG_OFFSET);
      wr(FLAG_CLR_OFFSET, 8'h01 << srcs[k]);
      fire(8'h01 << srcs[k]);
      idle(3);
    end
    // Random traffic, unmapped and read-only places included
    repeat (500)
    begin
      case ($urandom % 4)
        0:
        begin
          pick = $urandom % 5;
          pickData = 8'($urandom);
          if (addrs[pick] == PIE_OFFSET)
            pickData[RESERVED_BIT] = 1'b0;
          wr(addrs[pick], pickData);
        end
        1: rd(addrs[$urandom % 5]);
        2: fire(8'($urandom));
        default: idle(1);
      endcase
    end
    // Reset in mid-run clears everything again
    rst <= 1'b1;
    idle(2);
    rst <= 1'b0;
    foreach (addrs[k]) rd(addrs[k]);
    idle(4);
    conclude();
  end
endmodule

// ==== pieb_enable_reg.sv ====
// Software written register with a mask of writable bits
module pieb_enable_reg #(
  parameter logic [7:0] WRITE_MASK  = pieb_pkg::ALL_ONES,
  parameter logic [7:0] RESET_VALUE = pieb_pkg::PIE_RESET
) (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  // Software write
  input  wire logic                        wrStrobe,
  input  wire logic [pieb_pkg::REG_DW-1:0] wrData,
  // Stored value
  output logic      [pieb_pkg::REG_DW-1:0] regQ
);
  import pieb_pkg::*;

  // Bits outside the write mask ignore writes and stay at zero
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      regQ <= RESET_VALUE & WRITE_MASK;
    end
    else if (wrStrobe)
    begin
      regQ <= wrData & WRITE_MASK;
    end
  end

endmodule

// ==== pieb_flag_bank.sv ====
// Sticky event flags, set by hardware and cleared by software write of ones
module pieb_flag_bank #(
  parameter logic [7:0] IMPL_MASK = pieb_pkg::ALL_ONES
) (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  // Event pulses and clear request
  input  wire logic [pieb_pkg::REG_DW-1:0] setEvent,
  input  wire logic [pieb_pkg::REG_DW-1:0] clrBits,
  // Flag state
  output logic      [pieb_pkg::REG_DW-1:0] flagQ
);
  import pieb_pkg::*;

  // One sticky flag per source; an event in the clear cycle wins
  for (genvar i = 0; i < REG_DW; i++)
  begin : g_flag
    if (IMPL_MASK[i])
    begin : g_impl
      always_ff @(posedge ref_clk)
      begin
        if (rst)
        begin
          flagQ[i] <= FLAG_RESET[i];
        end
        else if (setEvent[i])
        begin
          flagQ[i] <= 1'b1;
        end
        else if (clrBits[i])
        begin
          flagQ[i] <= 1'b0;
        end
      end
    end
    else
    begin : g_none
      assign flagQ[i] = 1'b0;
    end
  end

endmodule

// ==== pieb_irq_enable_bank.sv ====
// Peripheral interrupt enable bank with flags, gates and register port
module pieb_irq_enable_bank #(
  parameter bit HAS_USART    = 1'b1,
  parameter bit HAS_PARALLEL = 1'b1
) (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  // Register port
  input  wire logic [pieb_pkg::REG_AW-1:0] regAddr,
  input  wire logic [pieb_pkg::REG_DW-1:0] regWrData,
  input  wire logic                        regWrEn,
  input  wire logic                        regRdEn,
  output logic      [pieb_pkg::REG_DW-1:0] regRdData,
  // Peripheral event pulses, one per source bit
  input  wire logic [pieb_pkg::REG_DW-1:0] srcEvent,
  // Interrupt request to the core
  output logic                             irqOut
);
  import pieb_pkg::*;

  // Bits that software can write in the enable register
  localparam logic [REG_DW-1:0] USART_PART =
    HAS_USART ? USART_MASK : 8'h00;
  localparam logic [REG_DW-1:0] PIE_WR_MASK =
    BASE_SRC_MASK | USART_PART | RESERVED_MASK | PARALLEL_MASK;

  // Bits that have a real event source behind them
  localparam logic [REG_DW-1:0] PARALLEL_PART =
    HAS_PARALLEL ? PARALLEL_MASK : 8'h00;
  localparam logic [REG_DW-1:0] SRC_MASK =
    BASE_SRC_MASK | USART_PART | PARALLEL_PART;

  // Decoder outputs
  pieb_rdsel_t               rdSel;
  logic                      pieWr;
  logic                      ctrlWr;
  logic                      clrWr;

  // Register contents and derived request
  logic [REG_DW-1:0]         pieQ;
  logic [REG_DW-1:0]         ctrlQ;
  logic [REG_DW-1:0]         flagQ;
  logic [REG_DW-1:0]         clrBits;
  logic [REG_DW-1:0]         liveEvent;
  logic [REG_DW-1:0]         pendingEn;
  logic                      gateOpen;
  logic                      irqReq;
  logic [REG_DW-1:0]         regRdData_q;
  logic [REG_DW-1:0]         regRdData_d;
  logic                      irq_q;

  // Address decoder for reads and writes
  always_comb
  begin
    rdSel  = RD_NONE;
    pieWr  = 1'b0;
    ctrlWr = 1'b0;
    clrWr  = 1'b0;
    if (regAddr == PIE_OFFSET)
    begin
      rdSel = RD_ENABLE;
      pieWr = regWrEn;
    end
    else if (regAddr == CTRL_OFFSET)
    begin
      rdSel  = RD_CTRL;
      ctrlWr = regWrEn;
    end
    else if (regAddr == FLAG_OFFSET)
    begin
      rdSel = RD_FLAG; // Read only, writes ignored
    end
    else if (regAddr == FLAG_CLR_OFFSET)
    begin
      clrWr = regWrEn; // Write only, reads give zero
    end
    else
    begin
      rdSel = RD_NONE; // Unmapped: writes dropped, reads zero
    end
  end

  // Per-source enable register; reserved bits stay writable
  pieb_enable_reg #(
    .WRITE_MASK  (PIE_WR_MASK),
    .RESET_VALUE (PIE_RESET)
  ) u_pie (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .wrStrobe (pieWr),
    .wrData   (regWrData),
    .regQ     (pieQ)
  );

  // Control register holding the peripheral gate and global enable
  pieb_enable_reg #(
    .WRITE_MASK  (CTRL_MASK),
    .RESET_VALUE (CTRL_RESET)
  ) u_ctrl (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .wrStrobe (ctrlWr),
    .wrData   (regWrData),
    .regQ     (ctrlQ)
  );

  // Events of absent sources are dropped before the flags
  assign liveEvent = srcEvent & SRC_MASK;
  assign clrBits   = regWrData & {REG_DW{clrWr}};

  // Sticky flags, independent of every enable
  pieb_flag_bank #(
    .IMPL_MASK (SRC_MASK)
  ) u_flags (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .setEvent (liveEvent),
    .clrBits  (clrBits),
    .flagQ    (flagQ)
  );

  // Request combine: per-source enable, then both gates
  assign pendingEn = flagQ & pieQ & SRC_MASK;
  assign gateOpen  = ctrlQ[PERIPH_GATE_BIT] & ctrlQ[GLOBAL_EN_BIT];
  assign irqReq    = (|pendingEn) & gateOpen;

  // Registered interrupt level to the core
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= irqReq;
    end
  end

  assign irqOut = irq_q;

  // Read mux; data valid only in the cycle after the strobe
  always_comb
  begin
    regRdData_d = 8'h00;
    if (regRdEn)
    begin
      case (rdSel)
        RD_ENABLE: regRdData_d = pieQ;
        RD_FLAG:   regRdData_d = flagQ;
        RD_CTRL:   regRdData_d = ctrlQ;
        default:   regRdData_d = 8'h00;
      endcase
    end
  end

  // Read data register
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      regRdData_q <= 8'h00;
    end
    else
    begin
      regRdData_q <= regRdData_d;
    end
  end

  assign regRdData = regRdData_q;

  // Named sequences for the register port checks
  sequence pieWriteS;
    regWrEn && (regAddr == PIE_OFFSET);
  endsequence

  sequence pieReadS;
    regRdEn && (regAddr == PIE_OFFSET);
  endsequence

  sequence clrWriteS;
    regWrEn && (regAddr == FLAG_CLR_OFFSET);
  endsequence

  sequence gateOpenS;
    ctrlQ[PERIPH_GATE_BIT] && ctrlQ[GLOBAL_EN_BIT];
  endsequence

  sequence ctrlWriteS;
    regWrEn && (regAddr == CTRL_OFFSET);
  endsequence

  sequence flagReadS;
    regRdEn && (regAddr == FLAG_OFFSET);
  endsequence

  // Event path steps: armed event, then settings left alone
  sequence armedEventS;
    ((liveEvent & pieQ & SRC_MASK) != 8'h00) &&
      ctrlQ[PERIPH_GATE_BIT] && ctrlQ[GLOBAL_EN_BIT];
  endsequence

  sequence settingsHeldS;
    $stable(pieQ) && $stable(ctrlQ);
  endsequence

  // Enable write stores the masked value
  pie_write_store_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    pieWriteS |=> (pieQ == ($past(regWrData) & PIE_WR_MASK)))
    else $error("enable register did not store write");

  // Enable read returns the stored bits one cycle later
  pie_read_back_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    pieReadS |=> (regRdData == $past(pieQ)))
    else $error("enable register read back wrong");

  // Missing USART bits never read as one
  usart_bits_zero_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (pieReadS and !HAS_USART) |=> (regRdData[5:4] == 2'b00))
    else $error("unimplemented enable bits read nonzero");

  // Reset release leaves everything cleared
  reset_clears_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    $fell(rst) |-> (pieQ == 8'h00) && (ctrlQ == 8'h00) &&
                   (flagQ == 8'h00) && !irqOut)
    else $error("state not cleared after reset");

  // Peripheral gate low blocks the request
  periph_gate_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !ctrlQ[PERIPH_GATE_BIT] |=> !irqOut)
    else $error("interrupt passed with peripheral gate low");

  // Global enable low blocks the request
  global_gate_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !ctrlQ[GLOBAL_EN_BIT] |=> !irqOut)
    else $error("interrupt passed with global enable low");

  // No enabled flag means no request
  src_enable_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    ((flagQ & pieQ & SRC_MASK) == 8'h00) |=> !irqOut)
    else $error("interrupt without enabled flag");

  // Enabled flag with open gates raises the request next cycle
  irq_raise_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    ((flagQ & pieQ & SRC_MASK) != 8'h00) ##0 gateOpenS
    |=> irqOut)
    else $error("interrupt missing for enabled flag");

  // Event sets its flag even while cleared or gated
  flag_sticky_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (liveEvent != 8'h00) |=>
      ((flagQ & $past(liveEvent)) == $past(liveEvent)))
    else $error("event lost its flag");

  // Clear without event drops the flag
  flag_clear_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    clrWriteS ##0 ((regWrData & liveEvent) == 8'h00) |=>
      ((flagQ & $past(regWrData)) == 8'h00))
    else $error("flag not cleared by clear write");

  // Read data stand only in the cycle after a read strobe
  rd_data_idle_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !regRdEn |=> (regRdData == 8'h00))
    else $error("read data present without read");

  // Request level stays while its cause stays
  irq_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    irqOut && irqReq ##1 irqReq |-> irqOut)
    else $error("interrupt dropped while cause held");

  // Control write stores only the two gate bits
  ctrl_write_store_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    ctrlWriteS |=> (ctrlQ == ($past(regWrData) & CTRL_MASK)))
    else $error("control register did not store write");

  // Enable register keeps its value between writes
  pie_hold_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !(regWrEn && (regAddr == PIE_OFFSET)) |=> $stable(pieQ))
    else $error("enable register changed without write");

  // Flag read returns the flags one cycle later
  flag_read_back_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    flagReadS |=> (regRdData == $past(flagQ)))
    else $error("flag register read back wrong");

  // Armed event with steady settings reaches the core two cycles on
  event_to_irq_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    armedEventS ##1 settingsHeldS |=> irqOut)
    else $error("armed event did not raise interrupt");

  // Flags move only by events and clear writes
  flag_ro_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (liveEvent == 8'h00) && !(regWrEn && (regAddr == FLAG_CLR_OFFSET))
    |=> $stable(flagQ))
    else $error("flags changed without event or clear");

  // Clear register and unmapped reads return zero
  clr_read_zero_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    (regRdEn && (rdSel == RD_NONE)) |=> (regRdData == 8'h00))
    else $error("write-only or unmapped read nonzero");

  // Request falls once its cause is gone
  irq_drop_a: assert property (
    @(posedge ref_clk) disable iff (rst)
    !irqReq |=> !irqOut)
    else $error("interrupt held without cause");

endmodule

// ==== pieb_periph_model.sv ====
// Peripheral event sources and core request watcher for the enable bank
module pieb_periph_model (
  // Clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  // Event requests from the bench
  input  wire logic [pieb_pkg::REG_DW-1:0] fireReq,
  // Event pulses to the bank
  output logic      [pieb_pkg::REG_DW-1:0] srcEvent,
  // Core side of the request
  input  wire logic                        irqOut,
  output int                               irqTaken
);
  timeunit 1ns;
  timeprecision 1ps;
  import pieb_pkg::*;

  logic irqSeenQ;

  // Each request is registered onto its event line a cycle later; no source sits behind bit 6
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      srcEvent <= '0;
    else
      srcEvent <= fireReq & ~RESERVED_MASK;
  end

  // Core counts every fresh request level it is handed
  always_ff @(posedge ref_clk)
  begin
    irqSeenQ <= rst ? 1'b0 : irqOut;
    if (rst)
      irqTaken <= 0;
    else if (irqOut && !irqSeenQ)
      irqTaken <= irqTaken + 1;
  end
endmodule

// ==== pieb_pkg.sv ====
// Package with register map, field layout and reset values of the enable bank
package pieb_pkg;

  // Bus widths
  localparam int REG_AW = 8;
  localparam int REG_DW = 8;

  // Register offsets
  localparam logic [REG_AW-1:0] PIE_OFFSET      = 8'h8c;
  localparam logic [REG_AW-1:0] CTRL_OFFSET     = 8'h0b;
  localparam logic [REG_AW-1:0] FLAG_OFFSET     = 8'h0c;
  localparam logic [REG_AW-1:0] FLAG_CLR_OFFSET = 8'h0d;

  // Source bit positions in the enable, flag and clear registers
  localparam int TIMER1_OVF_BIT  = 0;
  localparam int TIMER2_MAT_BIT  = 1;
  localparam int CAPCMP_BIT      = 2;
  localparam int SYNC_SERIAL_BIT = 3;
  localparam int USART_TX_BIT    = 4;
  localparam int USART_RX_BIT    = 5;
  localparam int RESERVED_BIT    = 6;
  localparam int PARALLEL_BIT    = 7;

  // Control register bit positions
  localparam int PERIPH_GATE_BIT = 6;
  localparam int GLOBAL_EN_BIT   = 7;

  // Field groups
  localparam logic [REG_DW-1:0] BASE_SRC_MASK = 8'h0f;
  localparam logic [REG_DW-1:0] USART_MASK    = 8'h30;
  localparam logic [REG_DW-1:0] RESERVED_MASK = 8'h40;
  localparam logic [REG_DW-1:0] PARALLEL_MASK = 8'h80;
  localparam logic [REG_DW-1:0] CTRL_MASK     = 8'hc0;
  localparam logic [REG_DW-1:0] ALL_ONES      = 8'hff;

  // Reset values
  localparam logic [REG_DW-1:0] PIE_RESET  = 8'h00;
  localparam logic [REG_DW-1:0] CTRL_RESET = 8'h00;
  localparam logic [REG_DW-1:0] FLAG_RESET = 8'h00;

  // Read source selected by the address decoder
  typedef enum logic [1:0] {
    RD_NONE,
    RD_ENABLE,
    RD_FLAG,
    RD_CTRL
  } pieb_rdsel_t;

endpackage
